// *** bench/mrrc_partner.sv ***
/*
  mrrc_partner: packet buffer writer taking appended status bytes, stalling
  every other cycle. assumes: shares mclk_i with mrrc_top.
*/
`timescale 1ns/1ps
`default_nettype none
module mrrc_partner (
  input  wire logic       mclk_i,
  input  wire logic       app_valid_i,
  input  wire logic [7:0] app_data_i,
  output logic            app_ready_o
);
  logic [7:0] q[$];
  logic       ready_q = 1'b0;
  assign app_ready_o = ready_q;
  // takes a byte only on valid and ready; ready flips every cycle
  always @(posedge mclk_i) begin
    if (app_valid_i && app_ready_o) q.push_back(app_data_i);
    ready_q <= ~ready_q;
  end
endmodule
`default_nettype wire

// *** bench/mrrc_tb_top.sv ***
/*
  mrrc_tb_top: self-checking bench for mrrc_top over APB.
  assumes: zero-wait APB slave, mrrc_partner takes appended bytes.
*/
`timescale 1ns/1ps
`default_nettype none
module mrrc_tb_top;
  logic mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
  logic [7:0] paddr_i = 0, app_data_o;
  logic [31:0] pwdata_i = 0, prdata_o;
  logic [1:0] transceiver_mode_i = 0;
  logic [3:0] channel_cfg_i = 4'h6;
  logic [2:0] rate_cfg_i = 3'h2;
  logic frame_format_i = 0, tx_start_i = 0, tx_fail_i = 0, tx_ok_i = 0, rx_busy_i = 0, cca_active_i = 0;
  logic ack_listen_i = 0, stream_buf_valid_i = 0, sec_done_i = 0, sec_tag_fail_i = 0, app_ready_i;
  logic pready_o, pslverr_o, rx_radio_on_o, rx_abort_o, parse_bypass_o, sec_start_o, rx_write_lock_o;
  logic frame_accept_o, frame_discard_o, repeat_send_o, tx_retry_o, tx_abort_o, wait_for_ack_o, app_valid_o;
  logic [6:0] ack_wait_units_o;
  mrrc_pkg::mrrc_ack_s ack_o;
  mrrc_pkg::mrrc_rx_frame_s rx_frame_i = {5'b00010, 7'h00, 16'hBEEF, 8'h00};
  mrrc_pkg::mrrc_rx_meas_s rx_meas_i = {8'hA5, 8'h3C, 8'h7E, 4'h9, 1'b1, 3'h5};
  logic [7:0] exp_b[4] = '{8'hA5, 8'h3C, 8'h9D, 8'h7E};
  int failures = 0, n_compared = 0;
  int n_pulse = 0;
  mrrc_top uut (.*);
  mrrc_partner p (.mclk_i(mclk_i), .app_valid_i(app_valid_o), .app_data_i(app_data_o), .app_ready_o(app_ready_i));
  always #50 mclk_i = ~mclk_i;
  // counts abort and security start pulses
  always @(negedge mclk_i) n_pulse += (rx_abort_o === 1'b1) + (sec_start_o === 1'b1);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge mclk_i) penable_i <= 1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 0; penable_i <= 0;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(0, a, 0, r);
    chk("register read", r, e);
  endtask
  task automatic pulse_chk(input string n, input logic acc, input logic [7:0] s);
    rx_frame_i.seq_num <= s; rx_frame_i.detect <= 1;
    @(posedge mclk_i) rx_frame_i.detect <= 0;
    @(negedge mclk_i) chk({n, " accept"}, frame_accept_o, acc);
    chk({n, " discard"}, frame_discard_o, !acc);
    if (acc) chk({n, " ack"}, {ack_o.send, ack_o.frame_pend, ack_o.channel}, {2'b11, 4'h6});
    @(posedge mclk_i);
  endtask
  task test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1;
    @(posedge mclk_i);
    rd(8'h50, 32'h30); rd(8'h54, 0); rd(8'h58, 0); rd(8'h5C, 32'h80);
    rd(8'h60, 0); chk("unmapped error", err, 1);
    wr(8'h58, 32'h54);
    wr(8'h54, 32'h9E);
    rd(8'h54, 32'h9E);
    pulse_chk("first", 1, 8'h01);
    rd(8'h58, 32'hD4);
    wr(8'h58, 32'h54); pulse_chk("repeat", 0, 8'h01);
    pulse_chk("second", 1, 8'h02); pulse_chk("blocked", 0, 8'h03);
    rd(8'h80, 32'h0E); wr(8'h80, 32'hFF); rd(8'h80, 0);
    chk("write lock", rx_write_lock_o, 1);
    foreach (exp_b[i]) chk("append byte", p.q[i], exp_b[i]);
    wr(8'h50, 32'h10); tx_start_i <= 1;
    @(posedge mclk_i) tx_fail_i <= 1;
    @(posedge mclk_i) tx_fail_i <= 0;
    @(negedge mclk_i) chk("retry", tx_retry_o, 1);
    @(posedge mclk_i) tx_fail_i <= 1;
    @(posedge mclk_i) tx_fail_i <= 0;
    @(negedge mclk_i) chk("abort", tx_abort_o, 1);
    @(posedge mclk_i) tx_start_i <= 0;
    @(posedge mclk_i);
    rd(8'h50, 32'h10); rd(8'h80, 32'h01);
    wr(8'h50, 0); chk("wait for ack", wait_for_ack_o, 0);
    transceiver_mode_i <= 2'b10; cca_active_i <= 1;
    repeat (2) @(posedge mclk_i);
    rd(8'h54, 32'h1E); chk("radio on", rx_radio_on_o, 1);
    chk("append count", p.q.size(), 8);
    chk("ack wait units", ack_wait_units_o, 1);
    wr(8'h5C, 32'h85);
    chk("ack wait units", ack_wait_units_o, 5);
    wr(8'h58, 32'h0F);
    wr(8'h54, 32'h40);
    chk("parse bypass", parse_bypass_o, 1);
    frame_format_i <= 1;
    transceiver_mode_i <= 2'b01;
    stream_buf_valid_i <= 1;
    @(posedge mclk_i);
    rd(8'h54, 32'hC0);
    rx_frame_i.repeat_req <= 1;
    rx_frame_i.info_ch <= 4'hB;
    rx_frame_i.info_dr <= 3'h3;
    rx_frame_i.seq_num <= 8'h04;
    rx_frame_i.detect <= 1;
    @(posedge mclk_i) rx_frame_i.detect <= 0;
    @(negedge mclk_i) chk("adaptive ack", {ack_o.send, ack_o.frame_pend, ack_o.channel, ack_o.rate}, {2'b10, 4'hB, 3'h3});
    chk("repeat send", repeat_send_o, 1);
    @(posedge mclk_i) frame_format_i <= 0;
    rx_frame_i.is_ack <= 1;
    rx_frame_i.frame_pend <= 1;
    rx_frame_i.detect <= 1;
    @(posedge mclk_i) rx_frame_i.detect <= 0;
    rd(8'h58, 32'hAF);
    rx_busy_i <= 1;
    wr(8'h54, 32'h40);
    rx_busy_i <= 0;
    chk("abort pulses", n_pulse, 1);
    wr(8'h54, 32'h60);
    rd(8'h54, 32'h60);
    sec_done_i <= 1;
    sec_tag_fail_i <= 1;
    @(posedge mclk_i) sec_done_i <= 0;
    rd(8'h54, 32'h40);
    rd(8'h80, 32'h29);
    chk("start pulses", n_pulse, 2);
    test_done();
  end
endmodule
`default_nettype wire

// *** common/mrrc_pkg.sv ***
/*
  mrrc_pkg: register indices, field positions, reset values, modes and carrier
  structs for the receive and retransmit control block.
  assumes: APB byte address = 4 * register index, 32-bit data, 8-bit registers.
*/
package mrrc_pkg;

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_RETX      = 6'h14;
  localparam logic [5:0] IDX_RX_PRI    = 6'h15;
  localparam logic [5:0] IDX_RX_SEC    = 6'h16;
  localparam logic [5:0] IDX_ACK_WAIT  = 6'h17;
  localparam logic [5:0] IDX_EVENTS    = 6'h20;

  // receive_control_primary fields
  localparam int unsigned PRI_RX_EN    = 7;
  localparam int unsigned PRI_BYPASS   = 6;
  localparam int unsigned PRI_SEC      = 5;
  localparam int unsigned PRI_APP_HI   = 4;
  localparam int unsigned PRI_APP_LO   = 1;

  // receive_control_secondary fields
  localparam int unsigned SEC_FULL     = 7;
  localparam int unsigned SEC_DUP_EN   = 6;
  localparam int unsigned SEC_ACK_RXFP = 5;
  localparam int unsigned SEC_ACK_TXFP = 4;
  localparam int unsigned SEC_RPT_EN   = 3;
  localparam int unsigned SEC_ACK_EN   = 2;
  localparam int unsigned SEC_ADPT_CH  = 1;
  localparam int unsigned SEC_ADPT_DR  = 0;

  // event register bits, write one to clear
  localparam int unsigned EV_TX_ACK    = 0;
  localparam int unsigned EV_OVERFLOW  = 1;
  localparam int unsigned EV_DUP       = 2;
  localparam int unsigned EV_RX_DONE   = 3;
  localparam int unsigned EV_DECRYPT   = 4;
  localparam int unsigned EV_TAG       = 5;
  localparam int unsigned EV_W         = 6;

  // reset values
  localparam logic [3:0] RETRY_LIMIT_RST = 4'h3;
  localparam logic [7:0] RX_PRI_RST      = 8'h00;
  localparam logic [7:0] RX_SEC_RST      = 8'h00;
  localparam logic [7:0] ACK_WAIT_RST    = 8'h80;

  typedef enum logic [1:0] {
    MODE_PACKET    = 2'b00,
    MODE_RX_STREAM = 2'b01,
    MODE_TX_STREAM = 2'b10,
    MODE_SPARE     = 2'b11
  } mrrc_mode_e;

  typedef enum logic [2:0] {
    APP_IDLE = 3'b000,
    APP_LQI  = 3'b001,
    APP_RSSI = 3'b010,
    APP_CHDR = 3'b011,
    APP_CFO  = 3'b100
  } mrrc_app_e;

  typedef struct packed {
    logic        detect;
    logic        is_ack;
    logic        frame_pend;
    logic        ack_req;
    logic        repeat_req;
    logic [3:0]  info_ch;
    logic [2:0]  info_dr;
    logic [15:0] src_addr;
    logic [7:0]  seq_num;
  } mrrc_rx_frame_s;

  typedef struct packed {
    logic [7:0] link_quality;
    logic [7:0] signal_strength;
    logic [7:0] freq_offset_measurement;
    logic [3:0] channel_select;
    logic       frame_format_select;
    logic [2:0] data_rate_select;
  } mrrc_rx_meas_s;

  typedef struct packed {
    logic       send;
    logic [3:0] channel;
    logic [2:0] rate;
    logic       frame_pend;
  } mrrc_ack_s;

endpackage

// *** verilog/mrrc_top.sv ***
/*
  mrrc_top: receive and retransmit control registers of a low-rate radio MAC,
  reached over APB, with the hardware side effects of those registers.
  assumes: all MAC datapath inputs are on mclk_i; APB master follows the
  two-phase protocol; the packet buffer writer honours app_valid_o/app_ready_i.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - retry_limit in bits 7..4 sets retries; zero means no waiting for ACK
// - attempt number counts retries; at limit a failure aborts and flags tx ACK
// - clearing rx enable mid-packet in packet or rx-stream mode aborts it
// - mode change to tx-stream clears rx enable, to rx-stream sets it
// - radio listens for CCA and ACK frames regardless of rx enable
// - parse bypass skips parsing, leaving only the CRC check
// - writing rx security start runs processing, self-clears, raises decrypt flag, or tag flag on tag failure
// - bits 4 and 3 append link quality and signal strength bytes
// - bit 2 appends channel, format and rate, packed MSB first
// - bit 1 appends the frequency offset byte
// - full buffer at a valid packet in packet mode raises overflow and blocks the write
// - packet mode sets buffer full on arrival; host clears it
// - rx-stream mode shows whether the read buffer holds a packet
// - duplicate rejection discards repeats and flags duplicate instead
// - ack_rx_pending_status mirrors pending bit of last ACK received with frame_format_i low
// - sent ACKs carry ack_tx_pending_value in the pending slot, zero when frame_format_i is set
// - auto repeat resends received packets carrying the repeat flag
// - auto ACK answers every accepted packet that requests one
// - with frame_format_i set, adaptive bits take ACK channel and rate from the ack_info_field
// - ACK wait is 1 to 127 units; zero acts as one unit
module mrrc_top (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [7:0]              paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic [31:0]                  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  input  wire logic [1:0]              transceiver_mode_i,
  input  wire logic                    frame_format_i,
  input  wire logic [3:0]              channel_cfg_i,
  input  wire logic [2:0]              rate_cfg_i,
  input  wire logic                    tx_start_i,
  input  wire logic                    tx_fail_i,
  input  wire logic                    tx_ok_i,
  input  wire logic                    rx_busy_i,
  input  wire logic                    cca_active_i,
  input  wire logic                    ack_listen_i,
  input  wire logic                    stream_buf_valid_i,
  input  wire mrrc_pkg::mrrc_rx_frame_s rx_frame_i,
  input  wire mrrc_pkg::mrrc_rx_meas_s rx_meas_i,
  input  wire logic                    sec_done_i,
  input  wire logic                    sec_tag_fail_i,
  input  wire logic                    app_ready_i,
  output logic                         rx_radio_on_o,
  output logic                         rx_abort_o,
  output logic                         parse_bypass_o,
  output logic                         sec_start_o,
  output logic                         rx_write_lock_o,
  output logic                         frame_accept_o,
  output logic                         frame_discard_o,
  output mrrc_pkg::mrrc_ack_s          ack_o,
  output logic                         repeat_send_o,
  output logic                         tx_retry_o,
  output logic                         tx_abort_o,
  output logic                         wait_for_ack_o,
  output logic [6:0]                   ack_wait_units_o,
  output logic                         app_valid_o,
  output logic [7:0]                   app_data_o
);

  // first pending append slot, in buffer order
  function automatic mrrc_pkg::mrrc_app_e app_pick(input logic [3:0] left);
    if (left[3]) return mrrc_pkg::APP_LQI;
    if (left[2]) return mrrc_pkg::APP_RSSI;
    if (left[1]) return mrrc_pkg::APP_CHDR;
    if (left[0]) return mrrc_pkg::APP_CFO;
    return mrrc_pkg::APP_IDLE;
  endfunction

  // byte carried by an append slot
  function automatic logic [7:0] app_byte(input mrrc_pkg::mrrc_app_e st, input mrrc_pkg::mrrc_rx_meas_s m);
    logic [7:0] b;
    b = 8'h00;
    unique case (st)
      mrrc_pkg::APP_IDLE: b = 8'h00;
      mrrc_pkg::APP_LQI:  b = m.link_quality;
      mrrc_pkg::APP_RSSI: b = m.signal_strength;
      mrrc_pkg::APP_CHDR: b = {m.channel_select, m.frame_format_select, m.data_rate_select};
      mrrc_pkg::APP_CFO:  b = m.freq_offset_measurement;
      default:            b = 8'h00;
    endcase
    return b;
  endfunction

  // register state
  logic [3:0]                retry_limit_reg;
  logic [3:0]                attempt_reg;
  logic                      rx_enable_reg;
  logic                      parse_bypass_reg;
  logic                      sec_busy_reg;
  logic [3:0]                append_en_reg;
  logic                      buf_full_reg;
  logic                      dup_en_reg;
  logic                      ack_rx_pend_reg;
  logic                      ack_tx_pend_reg;
  logic                      auto_rpt_reg;
  logic                      auto_ack_reg;
  logic                      adapt_ch_reg;
  logic                      adapt_dr_reg;
  logic [7:0]                ack_wait_reg;
  logic [mrrc_pkg::EV_W-1:0] events_reg;
  logic [1:0]                mode_prev_reg;
  logic                      tx_start_prev_reg;
  logic                      last_valid_reg;
  logic [15:0]               last_src_reg;
  logic [7:0]                last_seq_reg;
  logic [3:0]                app_left_reg;
  mrrc_pkg::mrrc_rx_meas_s   meas_reg;
  logic [7:0]                app_data_reg;
  logic [31:0]               prdata_reg;
  logic                      rx_abort_reg;
  logic                      sec_start_reg;
  logic                      accept_reg;
  logic                      discard_reg;
  logic                      repeat_reg;
  logic                      retry_reg;
  logic                      abort_reg;
  mrrc_pkg::mrrc_ack_s       ack_reg;

  // bus decode
  wire        apb_setup  = psel_i & ~penable_i;
  wire        apb_access = psel_i & penable_i;
  wire [5:0]  idx        = paddr_i[7:2];
  wire        aligned    = (paddr_i[1:0] == 2'b00);
  wire        hit_retx   = aligned & (idx == mrrc_pkg::IDX_RETX);
  wire        hit_pri    = aligned & (idx == mrrc_pkg::IDX_RX_PRI);
  wire        hit_sec    = aligned & (idx == mrrc_pkg::IDX_RX_SEC);
  wire        hit_wait   = aligned & (idx == mrrc_pkg::IDX_ACK_WAIT);
  wire        hit_ev     = aligned & (idx == mrrc_pkg::IDX_EVENTS);
  wire        addr_ok    = hit_retx | hit_pri | hit_sec | hit_wait | hit_ev;
  wire        wr_en      = apb_access & pwrite_i;
  wire        wr_retx    = wr_en & hit_retx;
  wire        wr_pri     = wr_en & hit_pri;
  wire        wr_sec     = wr_en & hit_sec;
  wire        wr_wait    = wr_en & hit_wait;
  wire        wr_ev      = wr_en & hit_ev;
  wire [7:0]  wbyte      = pwdata_i[7:0];

  // mode tracking
  wire mode_chg     = (transceiver_mode_i != mode_prev_reg);
  wire mode_packet  = (transceiver_mode_i == mrrc_pkg::MODE_PACKET);
  wire mode_rxs     = (transceiver_mode_i == mrrc_pkg::MODE_RX_STREAM);
  wire mode_txs     = (transceiver_mode_i == mrrc_pkg::MODE_TX_STREAM);
  wire rx_en_swclr  = wr_pri & ~wbyte[mrrc_pkg::PRI_RX_EN];
  wire rx_abort_now = rx_en_swclr & rx_enable_reg & rx_busy_i & (mode_packet | mode_rxs);

  wire rx_enable_next = (mode_chg & mode_txs) ? 1'b0 :
                        (mode_chg & mode_rxs) ? 1'b1 :
                        wr_pri ? wbyte[mrrc_pkg::PRI_RX_EN] : rx_enable_reg;

  // frame handling
  wire frame_det   = rx_frame_i.detect & ~rx_frame_i.is_ack & rx_enable_reg & ~rx_abort_now;
  wire is_dup      = dup_en_reg & last_valid_reg & (rx_frame_i.src_addr == last_src_reg)
                     & (rx_frame_i.seq_num == last_seq_reg);
  wire full_block  = buf_full_reg & mode_packet;
  wire accept      = frame_det & ~is_dup & ~full_block;
  wire overflow    = frame_det & ~is_dup & full_block;
  wire dup_hit     = frame_det & is_dup;
  wire ack_rx_seen = rx_frame_i.detect & rx_frame_i.is_ack & ~frame_format_i;
  wire buf_clr     = wr_sec & ~wbyte[mrrc_pkg::SEC_FULL];
  wire buf_full_next = (accept & mode_packet) ? 1'b1 :
                       buf_clr ? 1'b0 : buf_full_reg;

  // ack and repeat requests
  wire ack_fire    = accept & auto_ack_reg & rx_frame_i.ack_req;
  wire rpt_fire    = accept & auto_rpt_reg & rx_frame_i.repeat_req;
  wire [3:0] ack_ch = (frame_format_i & adapt_ch_reg) ? rx_frame_i.info_ch : channel_cfg_i;
  wire [2:0] ack_dr = (frame_format_i & adapt_dr_reg) ? rx_frame_i.info_dr : rate_cfg_i;
  wire ack_fp      = ~frame_format_i & ack_tx_pend_reg;

  // retransmission
  wire at_limit     = (attempt_reg == retry_limit_reg);
  wire tx_give_up   = tx_fail_i & at_limit;
  wire tx_again     = tx_fail_i & ~at_limit;
  wire tx_begin     = tx_start_i & ~tx_start_prev_reg;
  wire [3:0] attempt_next = (tx_begin | tx_ok_i | tx_give_up) ? 4'h0 :
                            tx_again ? 4'(attempt_reg + 4'h1) : attempt_reg;

  // receive security processing
  wire sec_kick     = wr_pri & wbyte[mrrc_pkg::PRI_SEC] & ~sec_busy_reg;
  wire sec_end      = sec_busy_reg & sec_done_i;
  wire sec_busy_next = sec_kick ? 1'b1 : (sec_end ? 1'b0 : sec_busy_reg);

  // sticky events, set wins over clear
  logic [mrrc_pkg::EV_W-1:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[mrrc_pkg::EV_TX_ACK]   = tx_give_up | tx_ok_i;
    ev_set[mrrc_pkg::EV_OVERFLOW] = overflow;
    ev_set[mrrc_pkg::EV_DUP]      = dup_hit;
    ev_set[mrrc_pkg::EV_RX_DONE]  = accept;
    ev_set[mrrc_pkg::EV_DECRYPT]  = sec_end & ~sec_tag_fail_i;
    ev_set[mrrc_pkg::EV_TAG]      = sec_end & sec_tag_fail_i;
  end
  wire [mrrc_pkg::EV_W-1:0] ev_clr  = wr_ev ? wbyte[mrrc_pkg::EV_W-1:0] : '0;
  wire [mrrc_pkg::EV_W-1:0] ev_next = (events_reg & ~ev_clr) | ev_set;

  // status appender
  wire mrrc_pkg::mrrc_app_e app_state = app_pick(app_left_reg);
  wire app_take = app_valid_o & app_ready_i;
  logic [3:0] app_drop;
  always_comb begin
    app_drop = 4'h0;
    unique case (app_state)
      mrrc_pkg::APP_IDLE: app_drop = 4'h0;
      mrrc_pkg::APP_LQI:  app_drop = 4'h8;
      mrrc_pkg::APP_RSSI: app_drop = 4'h4;
      mrrc_pkg::APP_CHDR: app_drop = 4'h2;
      mrrc_pkg::APP_CFO:  app_drop = 4'h1;
      default:            app_drop = 4'h0;
    endcase
  end
  wire [3:0] app_left_next = accept ? append_en_reg :
                             (app_take ? (app_left_reg & ~app_drop) : app_left_reg);
  wire mrrc_pkg::mrrc_rx_meas_s meas_next = accept ? rx_meas_i : meas_reg;
  wire [7:0] app_data_next = app_byte(app_pick(app_left_next), meas_next);

  // read mux
  wire full_view = mode_rxs ? stream_buf_valid_i : buf_full_reg;
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_retx) begin
      rd_byte = {retry_limit_reg, attempt_reg};
    end else if (hit_pri) begin
      rd_byte = {rx_enable_reg, parse_bypass_reg, sec_busy_reg, append_en_reg, 1'b0};
    end else if (hit_sec) begin
      rd_byte = {full_view, dup_en_reg, ack_rx_pend_reg, ack_tx_pend_reg,
                 auto_rpt_reg, auto_ack_reg, adapt_ch_reg, adapt_dr_reg};
    end else if (hit_wait) begin
      rd_byte = ack_wait_reg;
    end else if (hit_ev) begin
      rd_byte = {2'b00, events_reg};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      retry_limit_reg  <= mrrc_pkg::RETRY_LIMIT_RST;
      {parse_bypass_reg, append_en_reg} <= {mrrc_pkg::RX_PRI_RST[6], mrrc_pkg::RX_PRI_RST[4:1]};
      {dup_en_reg, ack_tx_pend_reg, auto_rpt_reg} <= {mrrc_pkg::RX_SEC_RST[6], mrrc_pkg::RX_SEC_RST[4:3]};
      {auto_ack_reg, adapt_ch_reg, adapt_dr_reg} <= mrrc_pkg::RX_SEC_RST[2:0];
      ack_wait_reg     <= mrrc_pkg::ACK_WAIT_RST;
    end else begin
      if (wr_retx) retry_limit_reg <= wbyte[7:4];
      if (wr_pri) {parse_bypass_reg, append_en_reg} <= {wbyte[mrrc_pkg::PRI_BYPASS],
                                                        wbyte[mrrc_pkg::PRI_APP_HI:mrrc_pkg::PRI_APP_LO]};
      if (wr_sec) {dup_en_reg, ack_tx_pend_reg, auto_rpt_reg} <= {wbyte[6], wbyte[4], wbyte[3]};
      if (wr_sec) {auto_ack_reg, adapt_ch_reg, adapt_dr_reg} <= wbyte[2:0];
      if (wr_wait) ack_wait_reg <= wbyte;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      attempt_reg <= 4'h0;
      rx_enable_reg <= mrrc_pkg::RX_PRI_RST[7];
      sec_busy_reg <= 1'b0;
      buf_full_reg <= mrrc_pkg::RX_SEC_RST[7];
      ack_rx_pend_reg <= mrrc_pkg::RX_SEC_RST[5];
      events_reg <= '0;
      mode_prev_reg <= mrrc_pkg::MODE_PACKET;
      tx_start_prev_reg <= 1'b0;
    end else begin
      attempt_reg <= attempt_next;
      rx_enable_reg <= rx_enable_next;
      sec_busy_reg <= sec_busy_next;
      buf_full_reg <= buf_full_next;
      if (ack_rx_seen) ack_rx_pend_reg <= rx_frame_i.frame_pend;
      events_reg <= ev_next;
      mode_prev_reg <= transceiver_mode_i;
      tx_start_prev_reg <= tx_start_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      last_valid_reg <= 1'b0;
      last_src_reg <= 16'h0000;
      last_seq_reg <= 8'h00;
      app_left_reg <= 4'h0;
      meas_reg <= '0;
      app_data_reg <= 8'h00;
      prdata_reg <= 32'h0000_0000;
    end else begin
      if (accept) {last_valid_reg, last_src_reg, last_seq_reg} <= {1'b1, rx_frame_i.src_addr, rx_frame_i.seq_num};
      app_left_reg <= app_left_next;
      meas_reg <= meas_next;
      app_data_reg <= app_data_next;
      if (apb_setup) prdata_reg <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      {rx_abort_reg, sec_start_reg, accept_reg, discard_reg} <= 4'h0;
      {repeat_reg, retry_reg, abort_reg} <= 3'b000;
      ack_reg <= '0;
    end else begin
      {rx_abort_reg, sec_start_reg, accept_reg, discard_reg} <= {rx_abort_now, sec_kick, accept, overflow | dup_hit};
      {repeat_reg, retry_reg, abort_reg} <= {rpt_fire, tx_again, tx_give_up};
      ack_reg <= '{send: ack_fire, channel: ack_ch, rate: ack_dr, frame_pend: ack_fp};
    end
  end

  // outputs
  assign pready_o         = apb_access;
  assign pslverr_o        = apb_access & ~addr_ok;
  assign prdata_o         = prdata_reg;
  assign rx_radio_on_o    = rx_enable_reg | cca_active_i | ack_listen_i;
  assign rx_abort_o       = rx_abort_reg;
  assign parse_bypass_o   = parse_bypass_reg;
  assign sec_start_o      = sec_start_reg;
  assign rx_write_lock_o  = full_block;
  assign frame_accept_o   = accept_reg;
  assign frame_discard_o  = discard_reg;
  assign ack_o            = ack_reg;
  assign repeat_send_o    = repeat_reg;
  assign tx_retry_o       = retry_reg;
  assign tx_abort_o       = abort_reg;
  assign wait_for_ack_o   = (retry_limit_reg != 4'h0);
  assign ack_wait_units_o = (ack_wait_reg[6:0] == 7'h00) ? 7'h01 : ack_wait_reg[6:0];
  assign app_valid_o      = (app_state != mrrc_pkg::APP_IDLE);
  assign app_data_o       = app_data_reg;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence sec_kicked;
    wr_pri && wbyte[5] && !sec_busy_reg;
  endsequence
  sequence sec_running;
    sec_busy_reg && sec_start_o;
  endsequence

  a_retry_zero_nowait: assert property (retry_limit_reg == 4'h0 |-> !wait_for_ack_o)
    else $error("zero retry limit still waits for ack");
  a_retry_limit_abort: assert property (tx_fail_i && attempt_reg == retry_limit_reg
      |=> tx_abort_o && events_reg[0] && attempt_reg == 4'h0)
    else $error("failure at limit did not abort");
  a_retry_count_step: assert property (tx_fail_i && attempt_reg != retry_limit_reg && !tx_begin
      |=> attempt_reg == $past(attempt_reg) + 4'h1 && tx_retry_o)
    else $error("attempt count did not advance");
  a_rx_abort_pulse: assert property (rx_abort_now |=> rx_abort_o ##1 !rx_abort_o)
    else $error("abort pulse missing");
  a_mode_rx_stream: assert property (mode_chg && mode_rxs |=> rx_enable_reg)
    else $error("rx stream mode did not set rx enable");
  a_mode_tx_stream: assert property (mode_chg && mode_txs |=> !rx_enable_reg)
    else $error("tx stream mode did not clear rx enable");
  a_radio_listen: assert property (cca_active_i || ack_listen_i |-> rx_radio_on_o)
    else $error("radio off during cca or ack listen");
  a_sec_start_busy: assert property (sec_kicked |=> sec_running ##1 !sec_start_o)
    else $error("security start not taken");
  a_overflow_hold: assert property (overflow |=> events_reg[1] && buf_full_reg && !frame_accept_o)
    else $error("overflow not flagged or buffer written");
  a_dup_flagged: assert property (dup_hit |=> events_reg[2] && frame_discard_o && !frame_accept_o)
    else $error("duplicate not rejected");
  a_ack_pending_bit: assert property (ack_fire && !frame_format_i |=> ack_o.send && ack_o.frame_pend == $past(ack_tx_pend_reg))
    else $error("ack pending bit wrong");
  a_ack_channel_pick: assert property (ack_fire && frame_format_i && adapt_ch_reg |=> ack_o.channel == $past(rx_frame_i.info_ch))
    else $error("adaptive ack channel not used");
  a_ack_wait_floor: assert property (ack_wait_units_o != 7'h00)
    else $error("ack wait of zero units");

endmodule

`default_nettype wire
